// *** inc/uvp_map.vh ***
`ifndef UVP_MAP_VH
`define UVP_MAP_VH
// Timing in ns, clock period 20 ns
`define UVP_CLK_NS        20
`define UVP_PW_MIN_NS     20000000
`define UVP_PW_MAX_NS     55000000
`define UVP_PW_NOM_NS     50000000
`define UVP_SETUP_NS      2000
`define UVP_HOLD_NS       2000
`define UVP_VR_NS         2000
`define UVP_DV_NS         1000
// Cycle counts (min rounds up)
`define UVP_SETUP_CYC     ((`UVP_SETUP_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_HOLD_CYC      ((`UVP_HOLD_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_VR_CYC        ((`UVP_VR_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_DV_CYC        ((`UVP_DV_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_PW_CYC        (`UVP_PW_NOM_NS / `UVP_CLK_NS)
// Operation codes
`define UVP_OP_READ       2'd0
`define UVP_OP_PROG       2'd1
`define UVP_OP_SIG        2'd2
// Erased byte value
`define UVP_ERASED        8'hff
`endif

// *** hw/uvp_sync.v ***
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser
// ****************************************
module uvp_sync #(
    parameter W = 8
) (
    input  wire         core_clk,
    input  wire         resetn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge core_clk) begin
        if (!resetn) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// *** hw/uvp_prog_host.v ***
// Notes on behaviour
// (RULE1) Chip select high: device standby, outputs float
// (RULE2) Device drives only with both selects low
// (RULE3) Chip select selects; gate shared read strobe
// (RULE4) Erased bits read one; programming writes zeros
// (RULE5) Programming never turns zero back to one
// (RULE6) Programming voltage on gate means program mode
// (RULE7) Byte presented on eight data pins
// (RULE8) Chip-select pulse within minimum and maximum width
// (RULE9) One pulse per location, any order
// (RULE10) Never program with static low select
// (RULE11) Shared inputs program parallel devices together
// (RULE12) Select high inhibits programming that device
// (RULE13) Read back each programmed location
// (RULE14) Sample only after data-valid delay
// (RULE15) Identifier voltage on address bit nine
// (RULE16) Bit zero picks maker or type code
// (RULE17) Other address lines low in signature
`timescale 1ns/1ps
`include "uvp_map.vh"
module uvp_prog_host #(
    parameter AW     = 12,
    parameter NDEV   = 1,
    parameter PW_CYC = `UVP_PW_CYC
) (
    input  wire            core_clk,
    input  wire            resetn,
    input  wire            cmd_valid,
    input  wire [1:0]      cmd_op,
    input  wire [AW-1:0]   cmd_addr,
    input  wire [7:0]      cmd_data,
    input  wire [NDEV-1:0] cmd_dev_sel,
    output reg             cmd_ready,
    output reg             rsp_valid,
    output reg  [7:0]      rsp_data,
    output reg             rsp_mismatch,
    output reg             rsp_bad_bits,
    output reg  [AW-1:0]   rom_addr,
    output reg  [NDEV-1:0] rom_cs_n,
    output reg             rom_oe_n,
    output reg             rom_vpp_en,
    output reg             rom_a9_hv_en,
    output reg  [7:0]      rom_dq_out,
    output reg             rom_dq_oe,
    input  wire [7:0]      rom_dq_in
);
    // ****************************************
    // States
    // ****************************************
    localparam [6:0] S_IDLE  = 7'b000_0001;
    localparam [6:0] S_SETUP = 7'b000_0010;
    localparam [6:0] S_PULSE = 7'b000_0100;
    localparam [6:0] S_HOLD  = 7'b000_1000;
    localparam [6:0] S_RECOV = 7'b001_0000;
    localparam [6:0] S_READ  = 7'b010_0000;
    localparam [6:0] S_DONE  = 7'b100_0000;
    localparam [31:0] SETUP_C = `UVP_SETUP_CYC;
    localparam [31:0] HOLD_C  = `UVP_HOLD_CYC;
    localparam [31:0] VR_C    = `UVP_VR_CYC;
    // Sync delay plus margin added to data-valid wait
    localparam [31:0] DV_C    = `UVP_DV_CYC + 32'd3;
    localparam [31:0] PW_C    = PW_CYC;

    reg  [6:0]      state_q;
    reg  [31:0]     cnt_q;
    reg  [1:0]      op_q;
    reg  [7:0]      data_q;
    reg             prog_q;
    wire [7:0]      dq_sync;

    uvp_sync #(.W(8)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      (rom_dq_in),
        .dout     (dq_sync)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge core_clk) begin
        if (!resetn) begin
            state_q      <= S_IDLE;
            cnt_q        <= 32'd0;
            op_q         <= `UVP_OP_READ;
            data_q       <= `UVP_ERASED;
            prog_q       <= 1'b0;
            cmd_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_data     <= 8'h00;
            rsp_mismatch <= 1'b0;
            rsp_bad_bits <= 1'b0;
            rom_addr     <= {AW{1'b0}};
            rom_cs_n     <= {NDEV{1'b1}}; // RULE1
            rom_oe_n     <= 1'b1;
            rom_vpp_en   <= 1'b0;
            rom_a9_hv_en <= 1'b0;
            rom_dq_out   <= `UVP_ERASED;
            rom_dq_oe    <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op_q      <= cmd_op;
                        data_q    <= cmd_data;
                        cnt_q     <= 32'd0;
                        if (cmd_op == `UVP_OP_PROG) begin
                            // RULE9
                            rom_addr   <= cmd_addr;
                            rom_dq_out <= cmd_data; // RULE7
                            rom_dq_oe  <= 1'b1;
                            rom_vpp_en <= 1'b1; // RULE6
                            prog_q     <= 1'b1;
                            state_q    <= S_SETUP;
                        end else if (cmd_op == `UVP_OP_SIG) begin
                            // RULE15 RULE17
                            rom_addr     <= {{(AW-1){1'b0}}, cmd_addr[0]}; // RULE16
                            rom_a9_hv_en <= 1'b1;
                            prog_q       <= 1'b0;
                            state_q      <= S_SETUP;
                        end else begin
                            rom_addr <= cmd_addr;
                            prog_q   <= 1'b0;
                            state_q  <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q >= SETUP_C - 32'd1) begin
                        cnt_q <= 32'd0;
                        if (prog_q) begin
                            rom_cs_n <= ~cmd_dev_sel; // RULE11 RULE12
                            state_q  <= S_PULSE;
                        end else begin
                            rom_cs_n <= ~cmd_dev_sel; // RULE3
                            rom_oe_n <= 1'b0; // RULE2
                            state_q  <= S_READ;
                        end
                    end
                end
                S_PULSE: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q >= PW_C - 32'd1) begin
                        // RULE8 RULE10
                        rom_cs_n <= {NDEV{1'b1}};
                        cnt_q    <= 32'd0;
                        state_q  <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q >= HOLD_C - 32'd1) begin
                        rom_dq_oe  <= 1'b0;
                        rom_vpp_en <= 1'b0;
                        cnt_q      <= 32'd0;
                        state_q    <= S_RECOV;
                    end
                end
                S_RECOV: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q >= VR_C - 32'd1) begin
                        // RULE13
                        rom_cs_n <= ~cmd_dev_sel;
                        rom_oe_n <= 1'b0;
                        cnt_q    <= 32'd0;
                        state_q  <= S_READ;
                    end
                end
                S_READ: begin
                    cnt_q <= cnt_q + 32'd1;
                    if (cnt_q >= DV_C - 32'd1) begin
                        // RULE14
                        rsp_data     <= dq_sync;
                        rsp_mismatch <= (op_q == `UVP_OP_PROG) && (dq_sync != data_q);
                        // RULE4 RULE5
                        rsp_bad_bits <= (op_q == `UVP_OP_PROG) && |(data_q & ~dq_sync);
                        rsp_valid    <= 1'b1;
                        rom_cs_n     <= {NDEV{1'b1}};
                        rom_oe_n     <= 1'b1;
                        rom_a9_hv_en <= 1'b0;
                        cnt_q        <= 32'd0;
                        state_q      <= S_DONE;
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// *** verification/uvp_eprom_model.sv ***
`timescale 1ns/1ps
module uvp_eprom_model #(
    parameter MK = 8'h5a, // Arbitrary maker value
    parameter DT = 8'ha5  // Arbitrary type value
) (
    input  wire [11:0] rom_addr,
    input  wire        rom_cs_n,
    input  wire        rom_oe_n,
    input  wire        rom_vpp_en,
    input  wire        rom_a9_hv_en,
    input  wire [7:0]  rom_dq_out,
    input  wire        rom_dq_oe,
    output wire [7:0]  rom_dq_in
);
    reg [7:0]  mem [0:4095];
    reg [7:0]  last_q = 8'h00;
    reg        ok_q = 1'b0;
    integer    k;
    wire       drv = !rom_cs_n && !rom_oe_n && !rom_vpp_en && ok_q;
    wire [7:0] val = rom_a9_hv_en ? (rom_addr[0] ? DT : MK) : mem[rom_addr];
    // Released bus shows inverse of last value
    assign rom_dq_in = drv ? val : ~last_q;
    initial for (k = 0; k < 4096; k = k + 1) mem[k] = 8'hff;
    always @(drv or val) if (drv) last_q = val;
    always @(negedge rom_cs_n) begin
        ok_q = 1'b0;
        // Data valid at the latest allowed point after select falls
        #1000 ok_q = !rom_cs_n;
    end
    always @(posedge rom_cs_n) begin
        ok_q = 1'b0;
        if (rom_vpp_en && rom_dq_oe) mem[rom_addr] = mem[rom_addr] & rom_dq_out;
    end
endmodule

// *** verification/uvp_prog_host_chk.sv ***
`timescale 1ns/1ps
`include "uvp_map.vh"
module uvp_prog_host_chk #(
    parameter AW     = 12,
    parameter NDEV   = 1,
    parameter PW_CYC = `UVP_PW_CYC
) (
    input wire            core_clk,
    input wire            resetn,
    input wire            cmd_valid,
    input wire            cmd_ready,
    input wire            rsp_valid,
    input wire [AW-1:0]   rom_addr,
    input wire [NDEV-1:0] rom_cs_n,
    input wire            rom_oe_n,
    input wire            rom_vpp_en,
    input wire            rom_a9_hv_en,
    input wire [7:0]      rom_dq_out,
    input wire            rom_dq_oe
);
    reg [31:0] pw_q;
    reg [31:0] lo_q;
    wire       pulse = ~&rom_cs_n && rom_vpp_en;
    always @(posedge core_clk) begin
        pw_q <= pulse ? pw_q + 1 : 32'h0;
        lo_q <= !rom_oe_n ? lo_q + 1 : 32'h0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_pulse_end;
        $rose(&rom_cs_n) ##0 rom_vpp_en;
    endsequence
    sequence s_back_ready;
        ##[1:3] cmd_ready;
    endsequence
    a_pulse_width: assert property (s_pulse_end |-> pw_q inside {[PW_CYC-1:PW_CYC+1]})
        else $error("program pulse width wrong");
    a_no_static_low: assert property (pulse |-> pw_q <= PW_CYC + 1)
        else $error("select held low too long");
    a_data_driven: assert property (pulse |-> rom_dq_oe)
        else $error("data not driven in pulse");
    a_pulse_stable: assert property (pulse |-> $stable(rom_addr) && $stable(rom_dq_out))
        else $error("address or data moved in pulse");
    a_verify_wait: assert property (rsp_valid |-> lo_q >= 50)
        else $error("sampled before data valid");
    a_gate_no_drive: assert property (!rom_oe_n |-> !rom_vpp_en && !rom_dq_oe)
        else $error("read strobe with drive or voltage");
    a_sig_addr_low: assert property (rom_a9_hv_en && ~&rom_cs_n |->
        {rom_addr[AW-1:10], rom_addr[8:1]} == 0)
        else $error("address lines high in signature");
    a_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready stayed high after accept");
    a_ready_back: assert property (rsp_valid |-> s_back_ready)
        else $error("ready not back after response");
endmodule
bind uvp_prog_host uvp_prog_host_chk #(.AW(AW), .NDEV(NDEV), .PW_CYC(PW_CYC)) u_chk (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .cmd_valid    (cmd_valid),
    .cmd_ready    (cmd_ready),
    .rsp_valid    (rsp_valid),
    .rom_addr     (rom_addr),
    .rom_cs_n     (rom_cs_n),
    .rom_oe_n     (rom_oe_n),
    .rom_vpp_en   (rom_vpp_en),
    .rom_a9_hv_en (rom_a9_hv_en),
    .rom_dq_out   (rom_dq_out),
    .rom_dq_oe    (rom_dq_oe)
);

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "uvp_map.vh"
module tb_top;
    localparam MK = 8'h5a; // Arbitrary maker value
    localparam DT = 8'ha5; // Arbitrary type value
    reg        core_clk = 0, resetn = 0, cmd_valid = 0, cmd_dev_sel = 1;
    reg [1:0]  cmd_op = 0;
    reg [11:0] cmd_addr = 0;
    reg [7:0]  cmd_data = 0;
    reg [7:0]  ref_m [0:4095];
    wire       cmd_ready, rsp_valid, rsp_mismatch, rsp_bad_bits, rom_cs_n, rom_oe_n;
    wire       rom_vpp_en, rom_a9_hv_en, rom_dq_oe;
    wire [7:0] rsp_data, rom_dq_out, rom_dq_in;
    wire [11:0] rom_addr;
    integer    n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 48978, i, a;
    uvp_prog_host #(.AW(12), .NDEV(1), .PW_CYC(20)) dut (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .cmd_valid    (cmd_valid),
        .cmd_op       (cmd_op),
        .cmd_addr     (cmd_addr),
        .cmd_data     (cmd_data),
        .cmd_dev_sel  (cmd_dev_sel),
        .cmd_ready    (cmd_ready),
        .rsp_valid    (rsp_valid),
        .rsp_data     (rsp_data),
        .rsp_mismatch (rsp_mismatch),
        .rsp_bad_bits (rsp_bad_bits),
        .rom_addr     (rom_addr),
        .rom_cs_n     (rom_cs_n),
        .rom_oe_n     (rom_oe_n),
        .rom_vpp_en   (rom_vpp_en),
        .rom_a9_hv_en (rom_a9_hv_en),
        .rom_dq_out   (rom_dq_out),
        .rom_dq_oe    (rom_dq_oe),
        .rom_dq_in    (rom_dq_in)
    );
    uvp_eprom_model #(.MK(MK), .DT(DT)) u_rom (
        .rom_addr     (rom_addr),
        .rom_cs_n     (rom_cs_n),
        .rom_oe_n     (rom_oe_n),
        .rom_vpp_en   (rom_vpp_en),
        .rom_a9_hv_en (rom_a9_hv_en),
        .rom_dq_out   (rom_dq_out),
        .rom_dq_oe    (rom_dq_oe),
        .rom_dq_in    (rom_dq_in)
    );
    always #10 core_clk = ~core_clk;
    task chk(input [7:0] seen, input [7:0] exp, input string nm);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task complete_run;
        begin
            $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
            if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task op(input [1:0] o, input [11:0] ad, input [7:0] d, input s);
        reg [7:0] e, n;
        begin
            @(negedge core_clk);
            {cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_dev_sel} = {1'b1, o, ad, d, s};
            // Ready seen settled at a falling edge; the next rising edge takes it
            while (cmd_ready !== 1'b1) @(negedge core_clk);
            @(negedge core_clk);
            cmd_valid = 0;
            do @(negedge core_clk); while (rsp_valid !== 1'b1);
            e = (o == `UVP_OP_SIG) ? (ad[0] ? DT : MK) : ref_m[ad];
            n = (o == `UVP_OP_PROG) ? (e & d) : e;
            if (s) begin
                if (o == `UVP_OP_PROG) ref_m[ad] = n;
                chk(rsp_data, n, "data");
                chk(rsp_mismatch, o == `UVP_OP_PROG && n != d, "mismatch");
                chk(rsp_bad_bits, o == `UVP_OP_PROG && (d & ~e) != 0, "bad_bits");
            end
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    initial begin
        for (i = 0; i < 4096; i = i + 1) ref_m[i] = 8'hff;
        repeat (8) @(negedge core_clk);
        resetn = 1;
        op(`UVP_OP_READ, 12'h7ff, 8'h00, 1);
        op(`UVP_OP_SIG, 12'hffe, 8'h00, 1);
        op(`UVP_OP_SIG, 12'hfff, 8'h00, 1);
        for (i = 0; i < 16; i = i + 1) begin
            a = $random(seed);
            op(`UVP_OP_PROG, a[11:0] & 12'h00f, a[23:16], a[31] | a[30]);
            op(`UVP_OP_READ, a[11:0] & 12'h00f, 8'h00, 1);
        end
        complete_run;
    end
endmodule
